// ==== rtl/rfs_pkg.sv ====
// rfs_pkg: constants for the regulator fault supervisor
// assumes a 200 MHz reference clock and an AXI4-Lite register bus
package rfs_pkg;
    localparam int          REF_CLK_MHZ        = 200;
    localparam int          OC_TIME_US         = 120;
    localparam int          SEVERE_TIME_US     = 2;
    localparam int          IMBAL_TIME_US      = 1000;
    localparam int          UV_TIME_US         = 1000;
    localparam int          OV_TIME_US         = 1000;
    localparam int          OC_CYCLES          = OC_TIME_US * REF_CLK_MHZ;
    localparam int          SEVERE_MAX_CYCLES  = SEVERE_TIME_US * REF_CLK_MHZ;
    localparam int          MS_CYCLES          = UV_TIME_US * REF_CLK_MHZ;
    localparam int          TIMER_W            = 20;
    // register byte offsets
    localparam logic [11:0] CTRL_OFFSET        = 12'h000;
    localparam logic [11:0] STATUS_OFFSET      = 12'h004;
    localparam logic [11:0] VOLTAGE_SELECT_CODE_OFFSET        = 12'h008;
    // control fields
    localparam int          CTRL_ENABLE_BIT    = 0;
    localparam int          CTRL_SET_A_BIT     = 1;
    localparam int          CTRL_SET_B_BIT     = 2;
    localparam int          CTRL_SET_C_BIT     = 3;
    localparam logic [3:0]  CTRL_RESET_VALUE   = 4'h8;
    localparam logic [5:0]  VOLTAGE_SELECT_CODE_RESET_VALUE   = 6'h0C;
    localparam logic [5:0]  VOLTAGE_SELECT_CODE_MAX_CODE      = 6'h28;
    localparam logic [5:0]  VOLTAGE_SELECT_CODE_BOOT_CODE     = 6'h0C;
    // status fields
    localparam int          ST_OC_BIT          = 0;
    localparam int          ST_SEVERE_BIT      = 1;
    localparam int          ST_IMBAL_BIT       = 2;
    localparam int          ST_UV_BIT          = 3;
    localparam int          ST_OV_BIT          = 4;
    localparam int          ST_ABS_OV_BIT      = 5;
    localparam int          ST_POWER_GOOD_OUT_BIT       = 6;
    localparam int          ST_THERM_BIT       = 7;
    localparam int          ST_TWO_PHASE_BIT   = 8;
    localparam int          ST_DIODE_BIT       = 9;
    localparam int          ST_FAST_BIT        = 10;
    localparam int          ST_CLAMP_BIT       = 11;
    localparam logic [1:0]  AXI_OKAY           = 2'h0;
    localparam logic [1:0]  AXI_SLVERR         = 2'h2;
    typedef enum logic [2:0] {RFS_OFF, RFS_SOFTSTART, RFS_RUN, RFS_FAULT} rfs_state_t;
endpackage : rfs_pkg

// ==== rtl/rfs_persist_timer.sv ====
// rfs_persist_timer: qualifies a level that must hold for a number of cycles
// assumes the qualifying level is already synchronous to i_ref_clk
`timescale 1ns/1ps
`default_nettype none
module rfs_persist_timer
    import rfs_pkg::*;
#(
    parameter int COUNT = 200
) (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_srst,
    // condition
    input  wire logic i_cond,
    output logic      o_expired
);
    typedef struct packed {
        logic [TIMER_W-1:0] count;
        logic               expired;
    } rfs_timer_t;

    rfs_timer_t state_reg;
    rfs_timer_t state_next;

    always_comb begin
        state_next = state_reg;
        // any dropout restarts the interval
        if (!i_cond) begin
            state_next.count   = '0;
            state_next.expired = 1'b0;
        end else if (state_reg.count >= TIMER_W'(COUNT - 1)) begin
            state_next.expired = 1'b1;
        end else begin
            state_next.count = state_reg.count + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_expired = state_reg.expired;
endmodule // rfs_persist_timer
`default_nettype wire

// ==== rtl/rfs_supervisor.sv ====
// rfs_supervisor: fault timers, fault latches, phase drive and slew select
// assumes comparator outputs arrive asynchronous and are synchronised here;
// i_srst is the supply-recycle reset, the enable bit is soft reset of faults
//
// What this block does
// - Overcurrent compares against full setpoint in two-phase, half setpoint in one-phase.
// - Overcurrent below twice setpoint latches fault after 120 us continuous.
// - Overcurrent above twice setpoint three-states phases and drops power-good at once.
// - Two-phase current-sense mismatch above 7.5 mV shuts down after 1 ms.
// - Output below target minus 300 mV for 1 ms latches undervoltage fault.
// - Output above target plus 200 mV for 1 ms latches overvoltage fault.
// - These faults latch power-good low and three-state both phase drives.
// - These faults clear only by enable low or supply reset; then soft-start again.
// - Output above 1.7 V: power-good low, low-side on until below 0.85 V; here enable low also releases the clamp early.
// - Rising above 1.7 V again after turn-off repeats the low-side clamp.
// - The 1.7 V latch survives enable toggles; only supply reset clears it.
// - The 1.7 V detector stays active while enabled, also after other faults.
// - Thermistor below 1.18 V drives thermal alert low at once, nothing else.
// - Slow slew at start-up; fast for changes when efficiency select a is high.
// - Slow source alone in soft-start; fast uses both sources together.
// - Source into slew cap when rising, sink when falling.
// - After enable, ramp slowly to the boot voltage.
// - Six-bit select code: 0 gives 1.500 V, 25 mV down per step, 0x28 gives 0.500 V.
// - Two phases in soft-start and while select c high; else one phase, diode emulation when only a.
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rfs_supervisor
    import rfs_pkg::*;
#(
    parameter int OC_COUNT    = OC_CYCLES,
    parameter int DELAY_COUNT = MS_CYCLES
) (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    // axi4-lite slave
    input  wire logic [11:0] i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [11:0] i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // comparator results, asynchronous
    input  wire logic        i_oc_full,
    input  wire logic        i_oc_half,
    input  wire logic        i_oc_double_full,
    input  wire logic        i_oc_double_half,
    input  wire logic        i_imbalance,
    input  wire logic        i_under_target,
    input  wire logic        i_over_target,
    input  wire logic        i_above_abs_ov,
    input  wire logic        i_below_clamp_release,
    input  wire logic        i_thermistor_low,
    input  wire logic        i_ramp_done,
    // power stage and system
    output logic             o_phase_one_enable,
    output logic             o_phase_two_enable,
    output logic             o_low_side_clamp,
    output logic             o_diode_emulation,
    output logic             o_power_good_out,
    output logic             o_thermal_alert_n,
    // slew control
    output logic             o_slow_slew_current,
    output logic             o_fast_slew_current,
    output logic             o_slew_source,
    output logic [5:0]       o_target_code
);
    localparam int NSYNC = 11;

    typedef struct packed {
        logic [NSYNC-1:0] sync1;
        logic [NSYNC-1:0] sync2;
        rfs_state_t       fsm;
        logic [3:0]       ctrl;
        logic [5:0]       voltage_select_code;
        logic [5:0]       target;
        logic             oc_flt, sev_flt, imb_flt, uv_flt, ov_flt;
        logic             abs_ov, clamp;
        logic             power_good_out;
        logic             slew_down;
        logic             aw_held, w_held;
        logic [11:0]      awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
    } rfs_sup_t;

    rfs_sup_t s_reg;
    rfs_sup_t s_next;

    logic [NSYNC-1:0] raw;
    logic             oc_full_s, oc_half_s, dbl_full_s, dbl_half_s, imb_s;
    logic             uv_s, ov_s, abs_s, rel_s, therm_s, done_s;
    logic             enabled, two_phase, oc_cond, sev_cond;
    logic             oc_exp, imb_exp, uv_exp, ov_exp;
    logic             any_flt, running;
    logic             wr_fire;
    logic [31:0]      status;

    assign raw = {i_ramp_done, i_thermistor_low, i_below_clamp_release, i_above_abs_ov, i_over_target,
                  i_under_target, i_imbalance, i_oc_double_half, i_oc_double_full, i_oc_half, i_oc_full};
    assign {done_s, therm_s, rel_s, abs_s, ov_s, uv_s, imb_s, dbl_half_s, dbl_full_s, oc_half_s, oc_full_s}
        = s_reg.sync2;

    assign enabled   = s_reg.ctrl[CTRL_ENABLE_BIT];
    assign two_phase = s_reg.ctrl[CTRL_SET_C_BIT];
    assign oc_cond   = two_phase ? oc_full_s : oc_half_s;
    assign sev_cond  = two_phase ? dbl_full_s : dbl_half_s;
    assign running   = (s_reg.fsm == RFS_SOFTSTART) || (s_reg.fsm == RFS_RUN);
    assign any_flt   = s_reg.oc_flt | s_reg.sev_flt | s_reg.imb_flt | s_reg.uv_flt | s_reg.ov_flt | s_reg.abs_ov;

    rfs_persist_timer #(.COUNT(OC_COUNT)) u_oc_timer (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cond(oc_cond & running & ~sev_cond), .o_expired(oc_exp)
    );
    rfs_persist_timer #(.COUNT(DELAY_COUNT)) u_imb_timer (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cond(imb_s & running & two_phase), .o_expired(imb_exp)
    );
    rfs_persist_timer #(.COUNT(DELAY_COUNT)) u_uv_timer (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cond(uv_s & (s_reg.fsm == RFS_RUN)), .o_expired(uv_exp)
    );
    rfs_persist_timer #(.COUNT(DELAY_COUNT)) u_ov_timer (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cond(ov_s & running), .o_expired(ov_exp)
    );

    always_comb begin
        status = '0;
        status[ST_OC_BIT]        = s_reg.oc_flt;
        status[ST_SEVERE_BIT]    = s_reg.sev_flt;
        status[ST_IMBAL_BIT]     = s_reg.imb_flt;
        status[ST_UV_BIT]        = s_reg.uv_flt;
        status[ST_OV_BIT]        = s_reg.ov_flt;
        status[ST_ABS_OV_BIT]    = s_reg.abs_ov;
        status[ST_POWER_GOOD_OUT_BIT]     = s_reg.power_good_out;
        status[ST_THERM_BIT]     = therm_s;
        status[ST_TWO_PHASE_BIT] = two_phase;
        status[ST_DIODE_BIT]     = o_diode_emulation;
        status[ST_FAST_BIT]      = o_fast_slew_current;
        status[ST_CLAMP_BIT]     = s_reg.clamp;
    end

    assign wr_fire = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;

    always_comb begin
        s_next       = s_reg;
        s_next.sync1 = raw;
        s_next.sync2 = s_reg.sync1;

        // write channel: take address and data in either order
        if (i_awvalid && o_awready) begin
            s_next.aw_held = 1'b1;
            s_next.awaddr  = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            s_next.w_held = 1'b1;
            s_next.wdata  = i_wdata;
            s_next.wstrb  = i_wstrb;
        end
        if (wr_fire) begin
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = AXI_OKAY;
            unique case (s_reg.awaddr)
                CTRL_OFFSET: if (s_reg.wstrb[0]) s_next.ctrl = s_reg.wdata[3:0];
                VOLTAGE_SELECT_CODE_OFFSET: begin
                    if (s_reg.wstrb[0] && s_reg.wdata[5:0] <= VOLTAGE_SELECT_CODE_MAX_CODE) s_next.voltage_select_code = s_reg.wdata[5:0];
                end
                STATUS_OFFSET: s_next.bresp = AXI_OKAY;
                default: s_next.bresp = AXI_SLVERR;
            endcase
        end
        if (s_reg.bvalid && i_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (i_arvalid && o_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = AXI_OKAY;
            unique case (i_araddr)
                CTRL_OFFSET:   s_next.rdata = {28'h0000000, s_reg.ctrl};
                STATUS_OFFSET: s_next.rdata = status;
                VOLTAGE_SELECT_CODE_OFFSET:   s_next.rdata = {26'h0000000, s_reg.voltage_select_code};
                default: begin
                    s_next.rdata = 32'h00000000;
                    s_next.rresp = AXI_SLVERR;
                end
            endcase
        end else if (s_reg.rvalid && i_rready) begin
            s_next.rvalid = 1'b0;
        end

        // faults: set wins; enable low clears all but the absolute latch
        if (!enabled) begin
            s_next.oc_flt  = 1'b0;
            s_next.sev_flt = 1'b0;
            s_next.imb_flt = 1'b0;
            s_next.uv_flt  = 1'b0;
            s_next.ov_flt  = 1'b0;
        end
        if (oc_exp)                   s_next.oc_flt  = 1'b1;
        if (sev_cond && running)      s_next.sev_flt = 1'b1;
        if (imb_exp)                  s_next.imb_flt = 1'b1;
        if (uv_exp)                   s_next.uv_flt  = 1'b1;
        if (ov_exp)                   s_next.ov_flt  = 1'b1;

        // absolute level watched whenever enabled, any state
        if (enabled && abs_s) begin
            s_next.abs_ov = 1'b1;
            s_next.clamp  = 1'b1;
        end else if (s_reg.clamp && rel_s) begin
            s_next.clamp = 1'b0;
        end
        if (!enabled) begin
            s_next.clamp = 1'b0;
        end

        unique case (s_reg.fsm)
            RFS_OFF: begin
                s_next.power_good_out = 1'b0;
                // soft-start only from a clean latch set
                if (enabled && !any_flt) begin
                    s_next.fsm    = RFS_SOFTSTART;
                    s_next.target = VOLTAGE_SELECT_CODE_BOOT_CODE;
                end
            end
            RFS_SOFTSTART: begin
                if (!enabled) s_next.fsm = RFS_OFF;
                else if (any_flt) s_next.fsm = RFS_FAULT;
                else if (done_s) begin
                    s_next.fsm    = RFS_RUN;
                    s_next.power_good_out  = 1'b1;
                    s_next.target = s_reg.voltage_select_code;
                end
            end
            RFS_RUN: begin
                s_next.target = s_reg.voltage_select_code;
                // direction must outlive the one cycle in which target lags voltage_select_code
                if (s_reg.voltage_select_code != s_reg.target) s_next.slew_down = (s_reg.voltage_select_code > s_reg.target);
                if (!enabled) s_next.fsm = RFS_OFF;
                else if (any_flt) s_next.fsm = RFS_FAULT;
            end
            RFS_FAULT: begin
                if (!enabled) s_next.fsm = RFS_OFF;
            end
            default: s_next.fsm = RFS_OFF;
        endcase
        // power-good drops the same cycle any latch sets
        if (s_next.oc_flt | s_next.sev_flt | s_next.imb_flt | s_next.uv_flt | s_next.ov_flt | s_next.abs_ov) begin
            s_next.power_good_out = 1'b0;
        end
        if (!enabled) s_next.power_good_out = 1'b0;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            s_reg        <= '0;
            s_reg.fsm    <= RFS_OFF;
            s_reg.ctrl   <= CTRL_RESET_VALUE;
            s_reg.voltage_select_code   <= VOLTAGE_SELECT_CODE_RESET_VALUE;
            s_reg.target <= VOLTAGE_SELECT_CODE_BOOT_CODE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_awready = ~s_reg.aw_held;
    assign o_wready  = ~s_reg.w_held;
    assign o_bvalid  = s_reg.bvalid;
    assign o_bresp   = s_reg.bresp;
    assign o_arready = ~s_reg.rvalid;
    assign o_rvalid  = s_reg.rvalid;
    assign o_rdata   = s_reg.rdata;
    assign o_rresp   = s_reg.rresp;

    // both drives three-state while any latch is set
    assign o_phase_one_enable  = running & ~any_flt;
    assign o_phase_two_enable  = running & ~any_flt & (two_phase | (s_reg.fsm == RFS_SOFTSTART));
    assign o_low_side_clamp    = s_reg.clamp;
    assign o_diode_emulation   = (s_reg.fsm == RFS_RUN) & ~two_phase & s_reg.ctrl[CTRL_SET_A_BIT]
                               & ~s_reg.ctrl[CTRL_SET_B_BIT];
    assign o_power_good_out    = s_reg.power_good_out;
    assign o_thermal_alert_n   = ~therm_s;
    // slow source always on while ramping; fast adds the second source
    assign o_slow_slew_current = running;
    assign o_fast_slew_current = (s_reg.fsm == RFS_RUN) & s_reg.ctrl[CTRL_SET_A_BIT];
    // lower code means higher voltage: source when the code moves down
    assign o_slew_source       = (s_reg.fsm == RFS_SOFTSTART) | ~s_reg.slew_down;
    assign o_target_code       = s_reg.target;

    property p_severe_trip;
        @(posedge i_ref_clk) disable iff (i_srst)
        (sev_cond && running) |=> !o_power_good_out && !o_phase_one_enable && !o_phase_two_enable;
    endproperty
    a_severe_trip: assert property (p_severe_trip) else $error("severe overcurrent did not shut down");

    property p_fault_holds;
        @(posedge i_ref_clk) disable iff (i_srst)
        (s_reg.uv_flt && enabled) |=> s_reg.uv_flt;
    endproperty
    a_fault_holds: assert property (p_fault_holds) else $error("undervoltage latch cleared while enabled");

    property p_abs_keep;
        @(posedge i_ref_clk) disable iff (i_srst)
        s_reg.abs_ov |=> s_reg.abs_ov;
    endproperty
    a_abs_keep: assert property (p_abs_keep) else $error("absolute overvoltage latch cleared");

    property p_abs_clamp;
        @(posedge i_ref_clk) disable iff (i_srst)
        (enabled && abs_s) |=> o_low_side_clamp && !o_power_good_out;
    endproperty
    a_abs_clamp: assert property (p_abs_clamp) else $error("no clamp on absolute overvoltage");

    property p_clamp_release;
        @(posedge i_ref_clk) disable iff (i_srst)
        (o_low_side_clamp && rel_s && !abs_s) |=> !o_low_side_clamp;
    endproperty
    a_clamp_release: assert property (p_clamp_release) else $error("clamp held past release level");

    property p_thermal;
        @(posedge i_ref_clk) disable iff (i_srst)
        therm_s |-> !o_thermal_alert_n;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal alert not asserted");

    property p_drives_off;
        @(posedge i_ref_clk) disable iff (i_srst)
        any_flt |-> !o_phase_one_enable && !o_phase_two_enable;
    endproperty
    a_drives_off: assert property (p_drives_off) else $error("phase driving with fault latched");

    property p_power_good_out_clean;
        @(posedge i_ref_clk) disable iff (i_srst)
        $rose(o_power_good_out) |-> $past(s_reg.fsm) == RFS_SOFTSTART;
    endproperty
    a_power_good_out_clean: assert property (p_power_good_out_clean) else $error("power good without soft-start");

    property p_single_phase;
        @(posedge i_ref_clk) disable iff (i_srst)
        (s_reg.fsm == RFS_RUN && !two_phase) |-> !o_phase_two_enable;
    endproperty
    a_single_phase: assert property (p_single_phase) else $error("phase two on in single phase");

    c_run: cover property (@(posedge i_ref_clk) disable iff (i_srst) $rose(o_power_good_out));
    c_oc: cover property (@(posedge i_ref_clk) disable iff (i_srst) $rose(s_reg.oc_flt));
    c_clamp: cover property (@(posedge i_ref_clk) disable iff (i_srst) $fell(o_low_side_clamp));
    c_fast: cover property (@(posedge i_ref_clk) disable iff (i_srst) $rose(o_fast_slew_current));
endmodule // rfs_supervisor
`default_nettype wire

// ==== test/rfs_power_stage.sv ====
// rfs_power_stage: behavioural output stage and slew node facing the supervisor
// assumes clamp, phase and slew controls come straight from the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module rfs_power_stage #(
    parameter int RAMP = 30,
    parameter int DROP = 12
) (
    // controls from the supervisor; surge from the bench
    input  wire logic i_ref_clk,
    input  wire logic i_phase_on,
    input  wire logic i_slow,
    input  wire logic i_clamp,
    input  wire logic i_surge,
    // analog levels back
    output logic      o_ramp_done,
    output logic      o_below_release
);
    int ramp_cnt = 0;
    int drop_cnt = 0;
    always @(posedge i_ref_clk) begin
        // slew node only climbs while something drives it
        if (!i_phase_on && !i_slow) ramp_cnt <= 0;
        else if (ramp_cnt < RAMP) ramp_cnt <= ramp_cnt + 1;
        // output only drains while the low side is clamped
        if (i_surge) drop_cnt <= 0;
        else if (i_clamp && drop_cnt < DROP) drop_cnt <= drop_cnt + 1;
    end
    assign o_ramp_done     = (ramp_cnt >= RAMP);
    assign o_below_release = (drop_cnt >= DROP);
endmodule // rfs_power_stage
`default_nettype wire

// ==== test/tb_regulator_fault_supervisor.sv ====
// tb_regulator_fault_supervisor: self-checking bench for rfs_supervisor
// assumes shortened fault timers and the behavioural power stage model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t ns: got %h expected %h", $time, g, e); end end
module tb_regulator_fault_supervisor;
    import rfs_pkg::*;
    localparam int OCN = 20;
    localparam int DN  = 50;
    logic        i_ref_clk = 0, i_srst = 1;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, ramp_done, below;
    logic        ph1, ph2, clamp, diode, power_good_out, alert_n, slow, fast, src;
    logic [1:0]  bresp, rresp;
    logic [8:0]  cmp = 0;
    logic [5:0]  target, voltage_select_code = VOLTAGE_SELECT_CODE_RESET_VALUE;
    logic [33:0] exp_q[$], msk_q[$], got, ex;
    int          error_cnt = 0, n_checks = 0, seed = 81744;
    int          st[7] = '{ST_OC_BIT, ST_OC_BIT, ST_SEVERE_BIT, ST_SEVERE_BIT, ST_IMBAL_BIT, ST_UV_BIT, ST_OV_BIT};
    always #2.5 i_ref_clk = ~i_ref_clk;
    rfs_supervisor #(.OC_COUNT(OCN), .DELAY_COUNT(DN)) uut (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_oc_full(cmp[0]), .i_oc_half(cmp[1]),
        .i_oc_double_full(cmp[2]), .i_oc_double_half(cmp[3]), .i_imbalance(cmp[4]), .i_under_target(cmp[5]),
        .i_over_target(cmp[6]), .i_above_abs_ov(cmp[7]), .i_below_clamp_release(below),
        .i_thermistor_low(cmp[8]), .i_ramp_done(ramp_done), .o_phase_one_enable(ph1), .o_phase_two_enable(ph2),
        .o_low_side_clamp(clamp), .o_diode_emulation(diode), .o_power_good_out(power_good_out),
        .o_thermal_alert_n(alert_n), .o_slow_slew_current(slow), .o_fast_slew_current(fast),
        .o_slew_source(src), .o_target_code(target));
    rfs_power_stage #(.RAMP(30), .DROP(12)) model (.i_ref_clk(i_ref_clk), .i_phase_on(ph1), .i_slow(slow),
        .i_clamp(clamp), .i_surge(cmp[7]), .o_ramp_done(ramp_done), .o_below_release(below));
    // bus answers are judged here against the oldest note
    always @(posedge i_ref_clk) begin
        if ((rvalid && rready) || (bvalid && bready)) begin
            got = (rvalid && rready) ? {rresp, rdata} : {bresp, 32'h0};
            got = got & msk_q.pop_front();
            ex = exp_q.pop_front();
            `CHK(got, ex)
        end
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic wait_lvl(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 1000) begin
            tick();
            n++;
        end
        if (s !== v) error_cnt++;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = AXI_OKAY);
        int t;
        t = 0;
        exp_q.push_back({r, 32'h0});
        msk_q.push_back('1);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            tick();
            t++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid && t < 100);
        // bready stays up between writes so back-to-back calls never drive it twice at one edge
        if (!bvalid) error_cnt++;
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e, input logic [33:0] m = '1);
        int t;
        t = 0;
        exp_q.push_back(e);
        msk_q.push_back(m);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            tick();
            t++;
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid && t < 100);
        if (!rvalid) error_cnt++;
    endtask
    task automatic start(input logic [3:0] cfg);
        int n;
        wr(CTRL_OFFSET, 32'h0);
        rd(STATUS_OFFSET, {AXI_OKAY, 32'h0}, {2'h3, 32'h1F});
        wr(CTRL_OFFSET, {28'h0, cfg | 4'h1});
        tick(3);
        `CHK({slow, fast, power_good_out, target}, {3'b100, VOLTAGE_SELECT_CODE_BOOT_CODE})
        wait_lvl(power_good_out, 1'b1, n);
        tick();
        `CHK({power_good_out, ph1, ph2, target}, {2'b11, cfg[3], voltage_select_code})
    endtask
    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        int n, cnt;
        logic [5:0] v;
        tick(5);
        i_srst <= 0;
        rd(CTRL_OFFSET, {AXI_OKAY, 28'h0, CTRL_RESET_VALUE});
        rd(12'hFFC, {AXI_SLVERR, 32'h0});
        `CHK({alert_n, power_good_out, ph1, target}, {3'b100, VOLTAGE_SELECT_CODE_RESET_VALUE})
        start(4'h8);
        cmp[8] <= 1;
        tick(4);
        `CHK({alert_n, power_good_out, ph1}, 3'b011)
        cmp[8] <= 0;
        repeat (3) begin
            v = 6'($unsigned($random(seed)) % 41);
            wr(VOLTAGE_SELECT_CODE_OFFSET, {26'h0, v});
            tick(4);
            `CHK(target, v)
            if (v != voltage_select_code) `CHK(src, v < voltage_select_code)
            voltage_select_code = v;
        end
        wr(VOLTAGE_SELECT_CODE_OFFSET, 32'h29);
        wr(STATUS_OFFSET, 32'hFFF);
        wr(12'h010, 32'h1, AXI_SLVERR);
        rd(VOLTAGE_SELECT_CODE_OFFSET, {AXI_OKAY, 26'h0, voltage_select_code});
        for (int c = 0; c < 8; c++) begin
            wr(CTRL_OFFSET, {28'h0, 3'(c), 1'b1});
            tick(4);
            `CHK({ph2, diode, fast}, {c[2], c == 1, c[0]})
        end
        // odd entries run one phase, so the half setpoint comparators apply
        for (int i = 0; i < 7; i++) begin
            start(i[0] ? 4'h0 : 4'h8);
            cnt = (i < 2) ? OCN : (i < 4) ? 0 : DN;
            if (cnt > 0) begin
                cmp[i] <= 1;
                tick(cnt - 2);
                cmp[i] <= 0;
                tick(2);
            end
            cmp[i] <= 1;
            wait_lvl(power_good_out, 1'b0, n);
            `CHK(n >= cnt && n <= cnt + 5, 1'b1)
            cmp[i] <= 0;
            tick(3);
            `CHK({power_good_out, ph1, ph2}, 3'b000)
            rd(STATUS_OFFSET, {AXI_OKAY, 32'h1 << st[i]}, {2'h3, 32'h3F});
        end
        cmp[7] <= 1;
        tick(5);
        `CHK({clamp, power_good_out}, 2'b10)
        cmp[7] <= 0;
        wait_lvl(clamp, 1'b0, n);
        `CHK({n < 40, ph1, ph2}, 3'b100)
        cmp[7] <= 1;
        tick(5);
        `CHK(clamp, 1'b1)
        cmp[7] <= 0;
        wait_lvl(clamp, 1'b0, n);
        wr(CTRL_OFFSET, 32'h0);
        wr(CTRL_OFFSET, 32'h9);
        tick(60);
        `CHK(power_good_out, 1'b0)
        rd(STATUS_OFFSET, {AXI_OKAY, 32'h20}, {2'h3, 32'h20});
        i_srst <= 1;
        tick(3);
        i_srst <= 0;
        voltage_select_code = VOLTAGE_SELECT_CODE_RESET_VALUE;
        rd(STATUS_OFFSET, {AXI_OKAY, 32'h0}, {2'h3, 32'h3F});
        start(4'h8);
        final_report();
    end
    // whole run needs about 1050 cycles; the 40000-cycle limit is over thirty times that
    initial begin
        #(5 * 40000);
        error_cnt++;
        final_report();
    end
endmodule // tb_regulator_fault_supervisor
`default_nettype wire
